// ==== rtl/ascd_defines.svh ====
// constants for the serial command decoder of the converter
// assumes inclusion by bare name from rtl sources only
`ifndef ASCD_DEFINES_SVH
`define ASCD_DEFINES_SVH
`define ASCD_RES_W            16
`define ASCD_NCHAN            8
`define ASCD_LEFT_FULL        5'h10
`define ASCD_MODE_RESET       8'h88
`define ASCD_CFG_RESET        4'h7
`define ASCD_NIB_CONV         4'h0
`define ASCD_NIB_MODE         4'h8
`define ASCD_M_EXT            3'h0
`define ASCD_M_ACQ            3'h1
`define ASCD_M_ICLK           3'h2
`define ASCD_M_RSV3           3'h3
`define ASCD_M_RESET          3'h4
`define ASCD_M_RSV5           3'h5
`define ASCD_M_PPD            3'h6
`define ASCD_M_FPD            3'h7
`define ASCD_EXT_SAMPLE_FALL  5'h0E
`define ASCD_ACQ_SAMPLE_FALL  5'h10
`define ASCD_ICLK_ARM_FALL    5'h08
`define ASCD_EXT_REARM_LEFT   5'h03
`define ASCD_ACQ_REARM_LEFT   5'h07
`define ASCD_ICLK_REARM_LEFT  5'h04
`define ASCD_ICLK_SAMPLE_TICK 5'h0B
`define ASCD_CONV_TICKS       5'h11
`define ASCD_OSC_DIV          2'h3
`define ASCD_SYS_PERIOD_NS    50
`define ASCD_ICLK_START_NS    100
`define ASCD_ICLK_START_CYC \
  ((`ASCD_ICLK_START_NS + `ASCD_SYS_PERIOD_NS - 1) / `ASCD_SYS_PERIOD_NS)
`endif

// ==== rtl/ascd_pkg.sv ====
// types and range decode for the serial command decoder
// assumes nothing beyond the defines header
`default_nettype none
`include "ascd_defines.svh"
package ascd_pkg;
  typedef enum logic [2:0] {
    ASCD_SPAN_NONE, ASCD_SPAN_6V, ASCD_SPAN_12V, ASCD_SPAN_24V, ASCD_SPAN_48V
  } ascd_span_t;
  typedef enum logic [1:0] {
    ASCD_POL_BIP, ASCD_POL_NEG, ASCD_POL_POS
  } ascd_pol_t;

  // full_scale_span of one configuration nibble, none when reserved
  function automatic ascd_span_t ascd_span(input logic [3:0] cfg);
    ascd_span_t s;
    s = ASCD_SPAN_NONE;
    case (cfg)
      4'h1, 4'h2, 4'h3: s = ASCD_SPAN_6V;
      4'h4, 4'h5, 4'h6, 4'h9: s = ASCD_SPAN_12V;
      4'h7, 4'hC: s = ASCD_SPAN_24V;
      4'hF: s = ASCD_SPAN_48V;
      default: s = ASCD_SPAN_NONE;
    endcase
    return s;
  endfunction : ascd_span

  function automatic ascd_pol_t ascd_pol(input logic [3:0] cfg);
    ascd_pol_t p;
    p = ASCD_POL_BIP;
    case (cfg)
      4'h2, 4'h5: p = ASCD_POL_NEG;
      4'h3, 4'h6: p = ASCD_POL_POS;
      default: p = ASCD_POL_BIP;
    endcase
    return p;
  endfunction : ascd_pol
endpackage : ascd_pkg
`default_nettype wire

// ==== rtl/ascd_link_if.sv ====
// synchronised serial link events passed from pin stage to core
// assumes one system clock domain
`timescale 1ns/100ps
`default_nettype none
interface ascd_link_if;
  logic sclk_rise;
  logic sclk_fall;
  logic din;
  logic cs_act;
  modport drv  (output sclk_rise, sclk_fall, din, cs_act);
  modport core (input  sclk_rise, sclk_fall, din, cs_act);
endinterface : ascd_link_if
`default_nettype wire

// ==== rtl/ascd_pin_sync.sv ====
// two-stage synchronisers and serial clock edge finder
// assumes pins asynchronous to sys_clk_i
`timescale 1ns/100ps
`default_nettype none
module ascd_pin_sync (
  input  wire logic  sys_clk_i,
  input  wire logic  rst_n_i,
  input  wire logic  sclk_i,
  input  wire logic  cs_n_i,
  input  wire logic  din_i,
  ascd_link_if.drv   link
);
  logic [1:0] sclk_s_q;
  logic [1:0] cs_n_s_q;
  logic [1:0] din_s_q;
  logic       sclk_d_q;
  logic       cs_n_d_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_s_q <= 2'h0;
      cs_n_s_q <= 2'h3;
      din_s_q  <= 2'h0;
      sclk_d_q <= 1'b0;
      cs_n_d_q <= 1'b1;
    end else begin
      sclk_s_q <= {sclk_s_q[0], sclk_i};
      cs_n_s_q <= {cs_n_s_q[0], cs_n_i};
      din_s_q  <= {din_s_q[0], din_i};
      sclk_d_q <= sclk_s_q[1];
      cs_n_d_q <= cs_n_s_q[1];
    end
  end

  // edges count only while chip select is low; a fall that meets the
  // release of chip select still counts
  assign link.cs_act    = ~cs_n_s_q[1];
  assign link.sclk_rise = ~cs_n_s_q[1] & sclk_s_q[1] & ~sclk_d_q;
  assign link.sclk_fall = ~cs_n_d_q & ~sclk_s_q[1] & sclk_d_q;
  assign link.din       = din_s_q[1];
endmodule : ascd_pin_sync
`default_nettype wire

// ==== rtl/ascd_top.sv ====
// serial command decoder, channel configuration and conversion sequencer
// assumes conv_result_i is a converter word on sys_clk_i
`timescale 1ns/100ps
`default_nettype none
`include "ascd_defines.svh"
// Function
// - single-ended range codes map to three spans
// - differential codes 001,100,111; others reserved
// - low nibble zero starts conversion
// - mode byte is start, mode, 1000
// - first high bit when idle starts command
// - external clock rearms after bits 15..3 out
// - external acquisition rearms after bits 15..7 out
// - internal clock rearms after bits 15..4 out
// - result out MSB first on falling edges
// - one configuration register per input
// - one eight-bit mode register
// - external clock samples at 14th falling edge
// - done strobe stays low in external clock
// - internal clock runs after one command byte
// - results are sixteen-bit codes
// - configuration byte is start, channel, diff, range
// - mode field decode with two reserved codes
// - rising captures, falling drives, idle when deselected
module ascd_top (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     sclk_i,
  input  wire logic                     cs_n_i,
  input  wire logic                     din_i,
  input  wire logic [`ASCD_RES_W-1:0]   conv_result_i,
  output logic                          dout_o,
  output logic                          dout_oe_o,
  output logic                          conversion_done_strobe_o,
  output logic                          sample_o,
  output logic [2:0]                    sample_chan_o,
  output logic                          diff_single_select_o,
  output ascd_pkg::ascd_span_t          full_scale_span_o,
  output ascd_pkg::ascd_pol_t           polarity_o,
  output logic [7:0]                    operating_mode_control_o,
  output logic                          partial_pd_o,
  output logic                          full_pd_o
);
  import ascd_pkg::*;
  typedef enum logic [2:0] {
    S_IDLE, S_EXT, S_ACQ, S_IARM, S_ISTART, S_IRUN, S_CONV} ascd_state_t;
  ascd_link_if lk ();
  ascd_state_t state_q;
  logic        rx_act_q;
  logic [2:0]  rx_cnt_q;
  logic [5:0]  rx_sh_q;
  logic [4:0]  fcnt_q;
  logic [4:0]  tmr_q;
  logic [4:0]  left_q;
  logic [1:0]  div_q;
  logic [15:0] res_q;
  logic [7:0]  mode_q;
  logic [3:0]  cfg_q [`ASCD_NCHAN];
  logic        strobe_q;
  logic        sample_q;
  logic [2:0]  chan_q;
  logic        diff_q;
  ascd_span_t  span_q;
  ascd_pol_t   pol_q;
  logic        osc_tick, start_ok, start_bit, byte_done;
  logic [7:0]  cmd_byte;
  logic        is_conv, is_mode, is_cfg, cfg_ok, mode_rst, pd;
  logic        ext_hit, acq_hit, int_hit, conv_end, load_now;
  logic [3:0]  cfg_sel;
  ascd_pin_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .sclk_i    (sclk_i),
    .cs_n_i    (cs_n_i),
    .din_i     (din_i),
    .link      (lk.drv)
  );
  // internal oscillator as a divided enable
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) div_q <= 2'h0;
    else div_q <= (div_q == `ASCD_OSC_DIV) ? 2'h0 : div_q + 2'h1;
  end
  assign osc_tick = (div_q == `ASCD_OSC_DIV);
  // start bit acceptance window
  always_comb begin
    start_ok = 1'b0;
    if (state_q == S_IDLE && !rx_act_q) begin
      case (mode_q[6:4])
        `ASCD_M_EXT:  start_ok = (left_q <= `ASCD_EXT_REARM_LEFT);
        `ASCD_M_ACQ:  start_ok = (left_q <= `ASCD_ACQ_REARM_LEFT);
        `ASCD_M_ICLK: start_ok = (left_q <= `ASCD_ICLK_REARM_LEFT);
        default:      start_ok = (left_q == 5'h00);
      endcase
    end
  end
  assign start_bit = lk.sclk_rise && lk.din && start_ok;
  // command byte receiver
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= 3'h0;
      rx_sh_q  <= 6'h00;
    end else if (!lk.cs_act) begin
      rx_act_q <= 1'b0;
    end else if (start_bit) begin
      rx_act_q <= 1'b1;
      rx_cnt_q <= 3'h0;
    end else if (lk.sclk_rise && rx_act_q) begin
      rx_sh_q  <= {rx_sh_q[4:0], lk.din};
      rx_cnt_q <= rx_cnt_q + 3'h1;
      if (rx_cnt_q == 3'h6) rx_act_q <= 1'b0;
    end
  end
  assign byte_done = lk.sclk_rise && rx_act_q && (rx_cnt_q == 3'h6);
  assign cmd_byte  = {1'b1, rx_sh_q, lk.din};
  assign is_conv   = (cmd_byte[3:0] == `ASCD_NIB_CONV);
  assign is_mode   = (cmd_byte[3:0] == `ASCD_NIB_MODE);
  assign is_cfg    = !is_conv && !is_mode;
  assign cfg_ok    = (ascd_span(cmd_byte[3:0]) != ASCD_SPAN_NONE);
  assign mode_rst  = byte_done && is_mode && cmd_byte[6:4] == `ASCD_M_RESET;
  assign cfg_sel   = cfg_q[cmd_byte[6:4]];
  // mode register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= `ASCD_MODE_RESET;
    end else if (byte_done && is_mode) begin
      case (cmd_byte[6:4])
        `ASCD_M_RESET: mode_q <= `ASCD_MODE_RESET;
        `ASCD_M_RSV3, `ASCD_M_RSV5: mode_q <= mode_q;
        default: mode_q <= cmd_byte;
      endcase
    end
  end
  assign pd = (mode_q[6:4] == `ASCD_M_PPD) || (mode_q[6:4] == `ASCD_M_FPD);
  // per-input configuration registers
  for (genvar i = 0; i < `ASCD_NCHAN; i++) begin : g_cfg
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) cfg_q[i] <= `ASCD_CFG_RESET;
      else if (mode_rst) cfg_q[i] <= `ASCD_CFG_RESET;
      else if (byte_done && is_cfg && cfg_ok && cmd_byte[6:4] == 3'(i))
        cfg_q[i] <= cmd_byte[3:0];
    end
  end
  // serial clock falls since the last start bit
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) fcnt_q <= 5'h00;
    else if (start_bit) fcnt_q <= 5'h00;
    else if (lk.sclk_fall && fcnt_q != 5'h1F) fcnt_q <= fcnt_q + 5'h01;
  end
  assign ext_hit  = state_q == S_EXT && lk.sclk_fall &&
                    fcnt_q == `ASCD_EXT_SAMPLE_FALL - 5'h01;
  assign acq_hit  = state_q == S_ACQ && lk.sclk_fall &&
                    fcnt_q == `ASCD_ACQ_SAMPLE_FALL - 5'h01;
  assign int_hit  = state_q == S_IRUN && osc_tick && tmr_q == 5'h01;
  assign conv_end = state_q == S_CONV && osc_tick && tmr_q == 5'h01;
  assign load_now = ext_hit || conv_end;
  // conversion sequencer
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= S_IDLE;
      tmr_q   <= 5'h00;
      chan_q  <= 3'h0;
      diff_q  <= 1'b0;
      span_q  <= ASCD_SPAN_24V;
      pol_q   <= ASCD_POL_BIP;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (byte_done && is_conv && !pd) begin
            chan_q <= cmd_byte[6:4];
            diff_q <= cfg_sel[3];
            span_q <= ascd_span(cfg_sel);
            pol_q  <= ascd_pol(cfg_sel);
            case (mode_q[6:4])
              `ASCD_M_EXT:  state_q <= S_EXT;
              `ASCD_M_ACQ:  state_q <= S_ACQ;
              `ASCD_M_ICLK: state_q <= S_IARM;
              default:      state_q <= S_IDLE;
            endcase
          end
        end
        S_EXT: if (ext_hit) state_q <= S_IDLE;
        S_ACQ: if (acq_hit) begin
          state_q <= S_CONV;
          tmr_q   <= `ASCD_CONV_TICKS;
        end
        S_IARM: if (lk.sclk_fall &&
                    fcnt_q == `ASCD_ICLK_ARM_FALL - 5'h01) begin
          state_q <= S_ISTART;
          tmr_q   <= 5'(`ASCD_ICLK_START_CYC);
        end
        S_ISTART: begin
          if (tmr_q <= 5'h01) begin
            state_q <= S_IRUN;
            tmr_q   <= `ASCD_ICLK_SAMPLE_TICK;
          end else begin
            tmr_q <= tmr_q - 5'h01;
          end
        end
        S_IRUN: begin
          if (int_hit) begin
            state_q <= S_CONV;
            tmr_q   <= `ASCD_CONV_TICKS;
          end else if (osc_tick) begin
            tmr_q <= tmr_q - 5'h01;
          end
        end
        S_CONV: begin
          if (conv_end) state_q <= S_IDLE;
          else if (osc_tick) tmr_q <= tmr_q - 5'h01;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
  // result shifter
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_q  <= 16'h0000;
      left_q <= 5'h00;
    end else if (load_now) begin
      res_q  <= conv_result_i;
      left_q <= `ASCD_LEFT_FULL;
    end else if (lk.sclk_fall && left_q != 5'h00) begin
      res_q  <= {res_q[14:0], 1'b0};
      left_q <= left_q - 5'h01;
    end
  end
  // done strobe: set wins over clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) strobe_q <= 1'b0;
    else if (conv_end) strobe_q <= 1'b1;
    else if (start_bit || (byte_done && is_mode)) strobe_q <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) sample_q <= 1'b0;
    else sample_q <= ext_hit || acq_hit || int_hit;
  end
  assign dout_o                   = res_q[15];
  assign dout_oe_o                = lk.cs_act;
  assign conversion_done_strobe_o = strobe_q;
  assign sample_o                 = sample_q;
  assign sample_chan_o            = chan_q;
  assign diff_single_select_o     = diff_q;
  assign full_scale_span_o        = span_q;
  assign polarity_o               = pol_q;
  assign operating_mode_control_o = mode_q;
  assign partial_pd_o             = mode_q[6:4] == `ASCD_M_PPD;
  assign full_pd_o                = mode_q[6:4] == `ASCD_M_FPD;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_STROBE_EXT: assert property (
    mode_q[6:4] == `ASCD_M_EXT |-> !strobe_q)
    else $error("done strobe high in external clock mode");
  AST_DOUT_IDLE: assert property (
    !lk.cs_act |-> !dout_oe_o ##1 !rx_act_q)
    else $error("link active while deselected");
  AST_EXT_SAMPLE: assert property (
    ext_hit |=> sample_q && left_q == 5'h10 && fcnt_q == 5'h0E)
    else $error("external clock sample not at 14th fall");
  AST_SHIFT: assert property (
    lk.sclk_fall && !load_now && left_q != 5'h00 |=>
      res_q == {$past(res_q[14:0]), 1'b0} && left_q == $past(left_q) - 5'h01)
    else $error("result not shifted msb first");
  AST_LOAD16: assert property (
    load_now |=> res_q == $past(conv_result_i) && left_q == 5'h10)
    else $error("result word not loaded whole");
  AST_MODE_WR: assert property (
    byte_done && is_mode && cmd_byte[6:4] inside {3'h0, 3'h1, 3'h2, 3'h6}
      |=> mode_q == $past(cmd_byte))
    else $error("mode register not written");
  AST_RSV_KEEP: assert property (
    byte_done && is_cfg && !cfg_ok |=> cfg_q[$past(cmd_byte[6:4])] ==
      $past(cfg_sel))
    else $error("reserved range changed configuration");
  AST_CFG_WR: assert property (
    byte_done && is_cfg && cfg_ok |=> cfg_q[$past(cmd_byte[6:4])] ==
      $past(cmd_byte[3:0]))
    else $error("configuration not stored");
  AST_RESET_DEF: assert property (
    mode_rst |=> mode_q == 8'h88 && cfg_q[0] == 4'h7 && cfg_q[7] == 4'h7)
    else $error("reset byte did not restore defaults");
  AST_REARM_EXT: assert property (
    state_q == S_IDLE && !rx_act_q && mode_q[6:4] == `ASCD_M_EXT &&
      left_q > 5'h03 && lk.sclk_rise |=> !rx_act_q)
    else $error("start accepted before bit 3 in external clock");
  AST_DONE_RISE: assert property (
    conv_end |=> strobe_q ##0 $rose(strobe_q))
    else $error("done strobe did not rise after conversion");
  COV_EXT: cover property (ext_hit);
  COV_ACQ: cover property (state_q == S_ACQ ##[1:300] $rose(strobe_q));
  COV_ICLK: cover property (int_hit);
  COV_RSV: cover property (byte_done && is_cfg && !cfg_ok);
endmodule : ascd_top
`default_nettype wire

// ==== dv/ascd_spi_master.sv ====
// serial master model driving the command port of the decoder
// assumes sys_clk_i is the bench clock; half a serial period is 4 cycles
`timescale 1ns/100ps
`default_nettype none
module ascd_spi_master (
  input  wire logic sys_clk_i,
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o
);
  int fall_cnt;

  initial begin
    sclk_o   = 1'b0;
    cs_n_o   = 1'b1;
    din_o    = 1'b0;
    fall_cnt = 0;
  end

  // n serial clocks, msb first; keeps the last 32 bits read
  task automatic frame(input logic [63:0] tx, input int n, input logic sel,
                       output logic [31:0] rx);
    rx       = '0;
    fall_cnt = 0;
    cs_n_o   = ~sel;
    repeat (4) @(negedge sys_clk_i);
    for (int i = 0; i < n; i++) begin
      din_o = tx[n-1-i];
      repeat (4) @(negedge sys_clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      rx       = {rx[30:0], sdo_i};
      sclk_o   = 1'b0;
      fall_cnt = fall_cnt + 1;
    end
    repeat (4) @(negedge sys_clk_i);
    cs_n_o = 1'b1;
    din_o  = ~din_o;
    repeat (4) @(negedge sys_clk_i);
  endtask : frame
endmodule : ascd_spi_master
`default_nettype wire

// ==== dv/test_adc_serial_command_decoder.sv ====
// self-checking bench for the serial command decoder
// assumes design files and the master model are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
  end
module test_adc_serial_command_decoder;
  import ascd_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sclk;
  logic        cs_n;
  logic        din;
  logic [15:0] res = 16'hC3A5;
  wire         sdo;
  logic        dout;
  logic        dout_oe;
  logic        strobe;
  logic        sample;
  logic [2:0]  chan;
  logic        diff;
  ascd_span_t  span;
  ascd_pol_t   pol;
  logic [7:0]  mode_reg;
  logic        ppd;
  logic        fpd;
  logic [31:0] rx;
  logic [3:0]  cfg [8];
  int          fail_count = 0;
  int          total_checks = 0;
  int          samples = 0;
  int          sample_at = 0;
  int          cyc = 0;

  assign sdo = dout_oe ? dout : 1'bz;

  ascd_top ascd_top_i (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n),
    .din_i(din), .conv_result_i(res), .dout_o(dout), .dout_oe_o(dout_oe),
    .conversion_done_strobe_o(strobe), .sample_o(sample),
    .sample_chan_o(chan), .diff_single_select_o(diff),
    .full_scale_span_o(span), .polarity_o(pol),
    .operating_mode_control_o(mode_reg), .partial_pd_o(ppd),
    .full_pd_o(fpd)
  );
  ascd_spi_master ascd_spi_master_i (
    .sys_clk_i(sys_clk), .sdo_i(sdo), .sclk_o(sclk), .cs_n_o(cs_n),
    .din_o(din)
  );

  always #25 sys_clk = ~sys_clk;

  // sample pulse counter and hang limit
  always @(negedge sys_clk) begin
    cyc++;
    if (sample === 1'b1) begin
      samples++;
      sample_at = ascd_spi_master_i.fall_cnt;
    end
    if (cyc == 60000) begin
      fail_count++;
      complete_run();
    end
  end

  function automatic ascd_span_t xspan(input logic [3:0] k);
    case (k)
      4'h1, 4'h2, 4'h3: return ASCD_SPAN_6V;
      4'h4, 4'h5, 4'h6, 4'h9: return ASCD_SPAN_12V;
      4'h7, 4'hC: return ASCD_SPAN_24V;
      4'hF: return ASCD_SPAN_48V;
      default: return ASCD_SPAN_NONE;
    endcase
  endfunction : xspan

  function automatic ascd_pol_t xpol(input logic [3:0] k);
    if (k == 4'h2 || k == 4'h5) return ASCD_POL_NEG;
    if (k == 4'h3 || k == 4'h6) return ASCD_POL_POS;
    return ASCD_POL_BIP;
  endfunction : xpol

  task automatic mode_byte(input logic [2:0] m);
    ascd_spi_master_i.frame({56'h0, 1'b1, m, 4'h8}, 8, 1'b1, rx);
  endtask : mode_byte

  task automatic wait_strobe();
    int k;
    k = 0;
    while (strobe !== 1'b1 && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    `CHK("strobe", 1'b1, strobe)
  endtask : wait_strobe

  // external clock conversion on channel c, result read in the same frame
  task automatic conv0(input logic [2:0] c);
    int s0;
    s0  = samples;
    res = res + 16'h1357;
    ascd_spi_master_i.frame({32'h0, 1'b1, c, 28'h0}, 32, 1'b1, rx);
    `CHK("samples", s0 + 1, samples)
    `CHK("sample at", 14, sample_at)
    `CHK("chan", c, chan)
    `CHK("diff", cfg[c][3], diff)
    `CHK("span", xspan(cfg[c]), span)
    `CHK("pol", xpol(cfg[c]), pol)
    `CHK("result", res, rx[17:2])
    `CHK("strobe", 1'b0, strobe)
    `CHK("oe", 1'b0, dout_oe)
  endtask : conv0

  task automatic cfg_scn();
    logic [3:0] codes [15];
    logic [2:0] c;
    codes = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hF,
              4'hA, 4'hB, 4'hD, 4'hE, 4'h7};
    for (int i = 0; i < 15; i++) begin
      c = 3'(i);
      ascd_spi_master_i.frame({56'h0, 1'b1, c, codes[i]}, 8, 1'b1, rx);
      if (codes[i] != 4'hA && codes[i] != 4'hB && codes[i] != 4'hD &&
          codes[i] != 4'hE)
        cfg[c] = codes[i];
      conv0(c);
      conv0(c + 3'h5);
    end
  endtask : cfg_scn

  task automatic mode_scn();
    logic [2:0] ms [8];
    logic [7:0] xm;
    int         s0;
    ms = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h5, 3'h4, 3'h0};
    xm = 8'h88;
    for (int i = 0; i < 8; i++) begin
      mode_byte(ms[i]);
      if (ms[i] != 3'h3 && ms[i] != 3'h5)
        xm = (ms[i] == 3'h4) ? 8'h88 : {1'b1, ms[i], 4'h8};
      `CHK("mode", xm, mode_reg)
      `CHK("ppd", xm[6:4] == 3'h6, ppd)
      `CHK("fpd", xm[6:4] == 3'h7, fpd)
      s0 = samples;
      if (xm[6:5] == 2'b11) begin
        ascd_spi_master_i.frame({56'h0, 8'hA0}, 8, 1'b1, rx);
        `CHK("pd samples", s0, samples)
      end
    end
    foreach (cfg[i]) cfg[i] = 4'h7;
    conv0(3'h3);
    ascd_spi_master_i.frame({56'h0, 8'hE8}, 8, 1'b0, rx);
    `CHK("mode kept", 8'h88, mode_reg)
  endtask : mode_scn

  // next start bit at clock pos of the read frame, accepted or refused
  task automatic probe(input logic [2:0] m, input int pos, input logic acc);
    logic [63:0] tx;
    int          n;
    int          s0;
    int          idx;
    mode_byte(m);
    res = res + 16'h1357;
    s0  = samples;
    if (m == 3'h1)
      ascd_spi_master_i.frame({48'h0, 16'hA000}, 16, 1'b1, rx);
    if (m == 3'h2)
      ascd_spi_master_i.frame({56'h0, 8'hA0}, 8, 1'b1, rx);
    if (m != 3'h0)
      wait_strobe();
    n  = (m == 3'h0) ? 29 : (m == 3'h1) ? 15 : 7;
    n  = acc ? pos + n : (m == 3'h0) ? 32 : 16;
    tx = '0;
    if (m == 3'h0)
      tx[n-1 -: 8] = 8'hA0;
    if (acc)
      tx[n-pos -: 8] = 8'hB0;
    else
      tx[n-pos] = 1'b1;
    ascd_spi_master_i.frame(tx, n, 1'b1, rx);
    idx = (m != 3'h0) ? n - 1 : acc ? 15 : 17;
    `CHK("result", res, rx[idx -: 16])
    if (!acc && m != 3'h0)
      `CHK("strobe kept", 1'b1, strobe)
    if (acc && m != 3'h2)
      `CHK("sample at", pos + ((m == 3'h0) ? 13 : 15), sample_at)
    if (acc && m != 3'h0) begin
      wait_strobe();
      ascd_spi_master_i.frame(64'h0, 16, 1'b1, rx);
      `CHK("result", res, rx[15:0])
    end
    `CHK("samples", s0 + 1 + int'(acc), samples)
  endtask : probe

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  initial begin
    foreach (cfg[i]) cfg[i] = 4'h7;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK("mode", 8'h88, mode_reg)
    `CHK("span", ASCD_SPAN_24V, span)
    `CHK("pol", ASCD_POL_BIP, pol)
    `CHK("diff", 1'b0, diff)
    `CHK("strobe", 1'b0, strobe)
    `CHK("oe", 1'b0, dout_oe)
    cfg_scn();
    mode_scn();
    probe(3'h0, 28, 1'b1);
    probe(3'h0, 27, 1'b0);
    probe(3'h1, 10, 1'b1);
    probe(3'h1, 9, 1'b0);
    probe(3'h2, 13, 1'b1);
    probe(3'h2, 12, 1'b0);
    complete_run();
  end
endmodule : test_adc_serial_command_decoder
`default_nettype wire
